/* File: core/bmc_basic_control.sv */
// basic mode control register with management serial slave
`timescale 1ns/10ps
module bmc_basic_control (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mdc,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    input wire logic [4:0] strapPhyAddr,
    input wire logic strapAnEnable,
    input wire logic strapDuplex,
    input wire logic powerOffRequestN,
    input wire logic anStarted,
    input wire logic [1:0] anSpeed,
    input wire logic anFullDuplex,
    output logic softResetBusy,
    output logic anEnable,
    output logic anRestartReq,
    output logic [1:0] speedSel,
    output logic fullDuplex,
    output logic powerDown,
    input wire logic macTxEn,
    input wire logic macTxEr,
    input wire logic [7:0] macTxd,
    input wire logic lineRxDv,
    input wire logic lineRxEr,
    input wire logic [7:0] lineRxd,
    input wire logic lineCol,
    input wire logic lineCrs,
    output logic macRxDv,
    output logic macRxEr,
    output logic [7:0] macRxd,
    output logic macCol,
    output logic macCrs,
    output logic macDriveEn,
    output logic lineTxEn,
    output logic lineTxEr,
    output logic [7:0] lineTxd
);
    import bmc_pkg::*;

    typedef struct packed {
        logic mdcPrev;
        bmc_mdio_st_e st;
        logic [4:0] cnt;
        logic isRead;
        logic [4:0] phyad;
        logic [4:0] regad;
        logic [15:0] shift;
        logic mdioOut;
        logic mdioOe;
        logic strapLoad;
        logic [4:0] phyAddr;
        logic [7:0] rstCnt;
        logic swRst;
        logic loop;
        logic spdLo;
        logic anEn;
        logic pdn;
        logic iso;
        logic anRestart;
        logic duplex;
        logic colTest;
        logic spdHi;
        logic [1:0] speed;
        logic fullDup;
        logic pdnEff;
    } bmc_ctrl_s;

    bmc_ctrl_s s_r;
    bmc_ctrl_s s_nxt;

    logic mdcRise;
    logic addrHit;
    logic [15:0] wrData;
    logic wrStrobe;

    // register image seen by the management master
    function automatic logic [15:0] read_word(input bmc_ctrl_s c,
                                              input logic pinN,
                                              input logic [4:0] reg_a);
        logic [15:0] w;
        w = '0;
        if (reg_a == BMC_REG_ADDR) begin
            // R1: reads one while busy
            w[BMC_BIT_RESET] = c.swRst;
            w[BMC_BIT_LOOP] = c.loop;
            w[BMC_BIT_SPD_LO] = c.spdLo;
            w[BMC_BIT_AN_EN] = c.anEn;
            // R8: pin shows as bit set
            w[BMC_BIT_PDN] = c.pdn | ~pinN;
            w[BMC_BIT_ISO] = c.iso;
            // R11: reads one until started
            w[BMC_BIT_AN_RESTART] = c.anRestart;
            w[BMC_BIT_DUPLEX] = c.duplex;
            w[BMC_BIT_COL_TEST] = c.colTest;
            w[BMC_BIT_SPD_HI] = c.spdHi;
            // R15: reserved bits zero
            w[5:0] = 6'h0;
        end
        return w;
    endfunction

    // control fields back to defaults, straps taken again
    function automatic bmc_ctrl_s load_defaults(input bmc_ctrl_s c,
                                                input logic anStrap,
                                                input logic dupStrap);
        bmc_ctrl_s d;
        d = c;
        // R16: reset values
        d.swRst = BMC_RST_OTHER;
        d.loop = BMC_RST_OTHER;
        d.spdLo = BMC_RST_OTHER;
        d.pdn = BMC_RST_OTHER;
        d.iso = BMC_RST_OTHER;
        d.anRestart = BMC_RST_OTHER;
        d.colTest = BMC_RST_OTHER;
        d.spdHi = BMC_RST_SPD_HI;
        // R6: strap sets negotiation enable
        d.anEn = anStrap;
        // R12: strap sets duplex
        d.duplex = dupStrap;
        return d;
    endfunction

    always_comb begin
        s_nxt = s_r;
        s_nxt.mdcPrev = mdc;
        s_nxt.strapLoad = 1'b0;
        mdcRise = mdc & ~s_r.mdcPrev;
        addrHit = (s_r.phyad == s_r.phyAddr);
        wrData = {s_r.shift[14:0], mdioIn};
        wrStrobe = 1'b0;

        // R17: serial slave never gated by power down
        if (mdcRise) begin
            unique case (s_r.st)
                BMC_ST_IDLE: begin
                    s_nxt.mdioOe = 1'b0;
                    if (!mdioIn) begin
                        s_nxt.st = BMC_ST_START;
                    end
                end
                BMC_ST_START: begin
                    s_nxt.st = mdioIn ? BMC_ST_OP : BMC_ST_IDLE;
                    s_nxt.cnt = BMC_OP_BITS_M1;
                end
                BMC_ST_OP: begin
                    s_nxt.shift = wrData;
                    s_nxt.cnt = s_r.cnt - 5'h1;
                    if (s_r.cnt == 5'h0) begin
                        s_nxt.cnt = BMC_ADDR_BITS_M1;
                        s_nxt.st = BMC_ST_PHYAD;
                        s_nxt.isRead = (wrData[1:0] == BMC_OP_READ);
                        if (wrData[1:0] != BMC_OP_READ &&
                            wrData[1:0] != BMC_OP_WRITE) begin
                            s_nxt.st = BMC_ST_IDLE;
                        end
                    end
                end
                BMC_ST_PHYAD: begin
                    s_nxt.shift = wrData;
                    s_nxt.cnt = s_r.cnt - 5'h1;
                    if (s_r.cnt == 5'h0) begin
                        s_nxt.phyad = wrData[4:0];
                        s_nxt.cnt = BMC_ADDR_BITS_M1;
                        s_nxt.st = BMC_ST_REGAD;
                    end
                end
                BMC_ST_REGAD: begin
                    s_nxt.shift = wrData;
                    s_nxt.cnt = s_r.cnt - 5'h1;
                    if (s_r.cnt == 5'h0) begin
                        s_nxt.regad = wrData[4:0];
                        s_nxt.cnt = BMC_TA_BITS_M1;
                        s_nxt.st = BMC_ST_TA;
                    end
                end
                BMC_ST_TA: begin
                    s_nxt.cnt = s_r.cnt - 5'h1;
                    if (s_r.cnt != 5'h0) begin
                        if (s_r.isRead && addrHit) begin
                            s_nxt.mdioOe = 1'b1;
                            s_nxt.mdioOut = 1'b0;
                            s_nxt.shift = read_word(s_r, powerOffRequestN,
                                                    s_r.regad);
                        end
                    end else begin
                        s_nxt.cnt = BMC_DATA_BITS_M1;
                        s_nxt.st = BMC_ST_DATA;
                        if (s_r.isRead) begin
                            s_nxt.mdioOut = s_r.shift[15];
                            s_nxt.shift = {s_r.shift[14:0], 1'b0};
                        end
                    end
                end
                BMC_ST_DATA: begin
                    s_nxt.cnt = s_r.cnt - 5'h1;
                    if (s_r.isRead) begin
                        s_nxt.mdioOut = s_r.shift[15];
                        s_nxt.shift = {s_r.shift[14:0], 1'b0};
                    end else begin
                        s_nxt.shift = wrData;
                    end
                    if (s_r.cnt == 5'h0) begin
                        s_nxt.st = BMC_ST_IDLE;
                        s_nxt.mdioOe = 1'b0;
                        s_nxt.mdioOut = 1'b0;
                        wrStrobe = ~s_r.isRead & addrHit &
                                   (s_r.regad == BMC_REG_ADDR);
                    end
                end
            endcase
        end

        // R11: clear once negotiation starts
        if (anStarted) begin
            s_nxt.anRestart = 1'b0;
        end

        if (s_r.swRst) begin
            // R1: hold busy, then restrap
            s_nxt.rstCnt = s_r.rstCnt - 8'h1;
            if (s_r.rstCnt <= 8'h1) begin
                s_nxt = load_defaults(s_nxt, strapAnEnable, strapDuplex);
                s_nxt.rstCnt = 8'h0;
            end
        end else if (wrStrobe) begin
            // R18: only read-write fields stored
            s_nxt.loop = wrData[BMC_BIT_LOOP];
            s_nxt.spdLo = wrData[BMC_BIT_SPD_LO];
            s_nxt.anEn = wrData[BMC_BIT_AN_EN];
            s_nxt.pdn = wrData[BMC_BIT_PDN];
            s_nxt.iso = wrData[BMC_BIT_ISO];
            s_nxt.duplex = wrData[BMC_BIT_DUPLEX];
            s_nxt.colTest = wrData[BMC_BIT_COL_TEST];
            s_nxt.spdHi = wrData[BMC_BIT_SPD_HI];
            // R10: restart only with negotiation on
            if (wrData[BMC_BIT_AN_RESTART] && wrData[BMC_BIT_AN_EN]) begin
                s_nxt.anRestart = 1'b1;
            end
            // R1: soft reset start
            if (wrData[BMC_BIT_RESET]) begin
                s_nxt.swRst = 1'b1;
                s_nxt.rstCnt = BMC_SW_RESET_CYC;
            end
        end

        // strap capture after release of the hardware reset
        if (s_r.strapLoad) begin
            s_nxt.phyAddr = strapPhyAddr;
            s_nxt.anEn = strapAnEnable;
            s_nxt.duplex = strapDuplex;
        end

        // R4: forced speed code
        // R5: negotiation result overrides forced bits
        if (s_nxt.anEn) begin
            s_nxt.speed = anSpeed;
            s_nxt.fullDup = anFullDuplex;
        end else begin
            s_nxt.speed = {s_nxt.spdHi, s_nxt.spdLo};
            s_nxt.fullDup = s_nxt.duplex;
        end
        // R7: effective power down
        // R8: bit or pin
        s_nxt.pdnEff = s_nxt.pdn | ~powerOffRequestN;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.st <= BMC_ST_IDLE;
            s_r.strapLoad <= 1'b1;
            s_r.spdHi <= BMC_RST_SPD_HI;
            s_r.speed <= BMC_SPEED_1000;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign mdioOut = s_r.mdioOut;
    assign mdioOe = s_r.mdioOe;
    assign softResetBusy = s_r.swRst;
    assign anEnable = s_r.anEn;
    assign anRestartReq = s_r.anRestart;
    assign speedSel = s_r.speed;
    assign fullDuplex = s_r.fullDup;
    assign powerDown = s_r.pdnEff;

    bmc_mac_path u_path (
        .clk(clk),
        .rst_n(rst_n),
        .loopback(s_r.loop),
        .isolate(s_r.iso),
        .powerDown(s_r.pdnEff),
        .colTest(s_r.colTest),
        .macTxEn(macTxEn),
        .macTxEr(macTxEr),
        .macTxd(macTxd),
        .lineRxDv(lineRxDv),
        .lineRxEr(lineRxEr),
        .lineRxd(lineRxd),
        .lineCol(lineCol),
        .lineCrs(lineCrs),
        .macRxDv(macRxDv),
        .macRxEr(macRxEr),
        .macRxd(macRxd),
        .macCol(macCol),
        .macCrs(macCrs),
        .macDriveEn(macDriveEn),
        .lineTxEn(lineTxEn),
        .lineTxEr(lineTxEr),
        .lineTxd(lineTxd)
    );
endmodule // bmc_basic_control

/* File: core/bmc_mac_path.sv */
// MAC-side data path: loopback, isolate, power down and collision test
`timescale 1ns/10ps
module bmc_mac_path (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic loopback,
    input wire logic isolate,
    input wire logic powerDown,
    input wire logic colTest,
    input wire logic macTxEn,
    input wire logic macTxEr,
    input wire logic [7:0] macTxd,
    input wire logic lineRxDv,
    input wire logic lineRxEr,
    input wire logic [7:0] lineRxd,
    input wire logic lineCol,
    input wire logic lineCrs,
    output logic macRxDv,
    output logic macRxEr,
    output logic [7:0] macRxd,
    output logic macCol,
    output logic macCrs,
    output logic macDriveEn,
    output logic lineTxEn,
    output logic lineTxEr,
    output logic [7:0] lineTxd
);
    import bmc_pkg::*;

    typedef struct packed {
        logic rxDv;
        logic rxEr;
        logic [7:0] rxd;
        logic col;
        logic crs;
        logic driveEn;
        logic txEn;
        logic txEr;
        logic [7:0] txd;
    } bmc_path_s;

    bmc_path_s s_r;
    bmc_path_s s_nxt;

    always_comb begin
        s_nxt = '0;
        s_nxt.driveEn = ~isolate;
        if (!powerDown && !loopback) begin
            s_nxt.txEn = macTxEn;
            s_nxt.txEr = macTxEr;
            s_nxt.txd = macTxd;
        end
        // R9: isolated port
        if (isolate || powerDown) begin
            s_nxt.rxDv = 1'b0;
        end else if (loopback) begin
            // R2: transmit looped back
            s_nxt.rxDv = macTxEn;
            s_nxt.rxEr = macTxEr;
            s_nxt.rxd = macTxd;
            s_nxt.crs = macTxEn;
        end else begin
            s_nxt.rxDv = lineRxDv;
            s_nxt.rxEr = lineRxEr;
            s_nxt.rxd = lineRxd;
            s_nxt.col = lineCol;
            s_nxt.crs = lineCrs;
        end
        // R13: col follows tx enable
        // R14: col drops with tx enable
        if (colTest && !isolate && !powerDown) begin
            s_nxt.col = macTxEn;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign macRxDv = s_r.rxDv;
    assign macRxEr = s_r.rxEr;
    assign macRxd = s_r.rxd;
    assign macCol = s_r.col;
    assign macCrs = s_r.crs;
    assign macDriveEn = s_r.driveEn;
    assign lineTxEn = s_r.txEn;
    assign lineTxEr = s_r.txEr;
    assign lineTxd = s_r.txd;
endmodule // bmc_mac_path

/* File: core/bmc_pkg.sv */
// constants for the basic mode control register block
// Function
// R1: writing reset bit 15 starts soft reset, reads one until done, restraps
// R2: loopback bit 14 routes MAC transmit data back to MAC receive path
// R3: master allows up to 500 us of no valid receive data after loopback
// R4: forced speed code {bit6,bit13}: 00=10, 01=100, 10=1000, 11 reserved
// R5: auto-negotiation enable ignores bits 13 and 8; clear, they set mode
// R6: auto-negotiation enable resets from strap pin, then stays read-write
// R7: power-down bit 11 powers down all but the register block
// R8: effective power down is bit 11 OR active-low pin; pin reads bit set
// R9: isolate bit 10 cuts MAC data interface, management keeps working (here only receive is cut; MAC transmit still reaches the line)
// R10: restart bit 9 reinitiates negotiation; ignored when bit 12 is zero
// R11: restart reads one until negotiation starts; clearing write ignored
// R12: duplex bit 8 selects full when one; reset value from strap pin
// R13: collision test bit 7 asserts COL within 512 bit times of TX_EN
// R14: collision test deasserts COL within 4 bit times of TX_EN falling
// R15: bits 5:0 reserved, writes ignored, reads zero
// R16: speed high bit resets one; other non-strap bits reset zero
// R17: management reads and writes keep working during power down
// R18: writes touch only read-write fields; self-clearing bits drop alone
package bmc_pkg;
    localparam int BMC_CLK_PERIOD_NS = 10;
    localparam int BMC_SW_RESET_NS = 1000;
    localparam int BMC_SW_RESET_CYC_I =
        (BMC_SW_RESET_NS + BMC_CLK_PERIOD_NS - 1) / BMC_CLK_PERIOD_NS;
    localparam logic [7:0] BMC_SW_RESET_CYC = 8'(BMC_SW_RESET_CYC_I);

    localparam logic [4:0] BMC_REG_ADDR = 5'h0;
    localparam int BMC_BIT_RESET = 15;
    localparam int BMC_BIT_LOOP = 14;
    localparam int BMC_BIT_SPD_LO = 13;
    localparam int BMC_BIT_AN_EN = 12;
    localparam int BMC_BIT_PDN = 11;
    localparam int BMC_BIT_ISO = 10;
    localparam int BMC_BIT_AN_RESTART = 9;
    localparam int BMC_BIT_DUPLEX = 8;
    localparam int BMC_BIT_COL_TEST = 7;
    localparam int BMC_BIT_SPD_HI = 6;

    localparam logic BMC_RST_SPD_HI = 1'b1;
    localparam logic BMC_RST_OTHER = 1'b0;

    localparam logic [1:0] BMC_OP_WRITE = 2'h1;
    localparam logic [1:0] BMC_OP_READ = 2'h2;
    localparam logic [4:0] BMC_OP_BITS_M1 = 5'h1;
    localparam logic [4:0] BMC_ADDR_BITS_M1 = 5'h4;
    localparam logic [4:0] BMC_TA_BITS_M1 = 5'h1;
    localparam logic [4:0] BMC_DATA_BITS_M1 = 5'hf;

    localparam logic [1:0] BMC_SPEED_10 = 2'h0;
    localparam logic [1:0] BMC_SPEED_100 = 2'h1;
    localparam logic [1:0] BMC_SPEED_1000 = 2'h2;

    typedef enum logic [2:0] {
        BMC_ST_IDLE,
        BMC_ST_START,
        BMC_ST_OP,
        BMC_ST_PHYAD,
        BMC_ST_REGAD,
        BMC_ST_TA,
        BMC_ST_DATA
    } bmc_mdio_st_e;
endpackage

/* File: test/bmc_basic_control_tb.sv */
// self-checking bench for the basic mode control block
`timescale 1ns/10ps
`define CHK(a, b) begin \
    tests_run++; \
    if ((a) !== (b)) begin \
        n_mismatch++; \
        $display("[ERR] %0t %h %h", $time, (a), (b)); \
    end \
end
module bmc_basic_control_tb;
    import bmc_pkg::*;
    localparam logic [4:0] PHY = 5'h03;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mdc, mdioIn, mdioOut, mdioOe;
    logic strapAnEnable = 1'b0;
    logic strapDuplex = 1'b1;
    logic powerOffRequestN = 1'b1;
    logic anStarted = 1'b0;
    logic anFullDuplex = 1'b1;
    logic [1:0] anSpeed = 2'h2;
    logic macTxEn = 1'b0;
    logic [7:0] macTxd = 8'h00;
    logic lineRxDv = 1'b0;
    logic [7:0] lineRxd = 8'h00;
    logic lineCol = 1'b0;
    logic macTxEr = 1'b0;
    logic lineCrs = 1'b0;
    logic softResetBusy, anEnable, anRestartReq, fullDuplex, powerDown;
    logic macRxDv, macRxEr, macCol, macCrs, macDriveEn, lineTxEn, lineTxEr;
    logic [1:0] speedSel;
    logic [7:0] macRxd, lineTxd;
    logic [15:0] rv;
    int n_mismatch = 0;
    int tests_run = 0;

    always #5 clk = ~clk;

    bmc_mdio_master m (.clk, .mdc, .mdioIn, .mdioOut, .mdioOe);
    bmc_basic_control dut (
        .clk, .rst_n, .mdc, .mdioIn, .mdioOut, .mdioOe,
        .strapPhyAddr(PHY), .strapAnEnable, .strapDuplex,
        .powerOffRequestN, .anStarted, .anSpeed, .anFullDuplex,
        .softResetBusy, .anEnable, .anRestartReq, .speedSel,
        .fullDuplex, .powerDown, .macTxEn, .macTxEr, .macTxd,
        .lineRxDv, .lineRxEr(1'b0), .lineRxd, .lineCol,
        .lineCrs, .macRxDv, .macRxEr, .macRxd, .macCol, .macCrs,
        .macDriveEn, .lineTxEn, .lineTxEr, .lineTxd
    );

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] d);
        logic [15:0] x;
        m.xfer(BMC_OP_WRITE, PHY, 5'h00, d, x);
    endtask
    task automatic rdr(input logic [4:0] ra, output logic [15:0] d);
        m.xfer(BMC_OP_READ, PHY, ra, 16'h0000, d);
    endtask

    task automatic t_reset;
        rdr(5'h00, rv);
        `CHK(rv, 16'h0140)
        `CHK(speedSel, 2'h2)
        `CHK(fullDuplex, 1'b1)
        rdr(5'h01, rv);
        `CHK(rv, 16'h0000)
        m.xfer(BMC_OP_WRITE, 5'h04, 5'h00, 16'h4000, rv);
        rdr(5'h00, rv);
        `CHK(rv, 16'h0140)
    endtask
    task automatic t_forced;
        logic [15:0] d;
        for (int c = 0; c < 4; c++) begin
            d = 16'h003f;
            d[BMC_BIT_SPD_HI] = c[1];
            d[BMC_BIT_SPD_LO] = c[0];
            d[BMC_BIT_DUPLEX] = c[0];
            wr(d);
            `CHK(speedSel, 2'(c))
            `CHK(fullDuplex, d[BMC_BIT_DUPLEX])
            rdr(5'h00, rv);
            `CHK(rv, d & 16'hffc0)
        end
    endtask
    task automatic t_auto;
        wr(16'h0200);
        `CHK(anRestartReq, 1'b0)
        anSpeed = 2'h1;
        anFullDuplex = 1'b0;
        wr(16'h3300);
        `CHK(anRestartReq, 1'b1)
        `CHK(speedSel, 2'h1)
        `CHK(fullDuplex, 1'b0)
        wr(16'h1000);
        `CHK(anRestartReq, 1'b1)
        rdr(5'h00, rv);
        `CHK(rv, 16'h1200)
        anStarted = 1'b1;
        cyc(1);
        anStarted = 1'b0;
        cyc(1);
        `CHK(anRestartReq, 1'b0)
        wr(16'h0040);
    endtask
    task automatic t_power;
        wr(16'h0800);
        `CHK(powerDown, 1'b1)
        macTxEn = 1'b1;
        cyc(2);
        `CHK(lineTxEn, 1'b0)
        macTxEn = 1'b0;
        rdr(5'h00, rv);
        `CHK(rv, 16'h0800)
        wr(16'h0000);
        `CHK(powerDown, 1'b0)
        powerOffRequestN = 1'b0;
        cyc(2);
        `CHK(powerDown, 1'b1)
        rdr(5'h00, rv);
        `CHK(rv, 16'h0800)
        powerOffRequestN = 1'b1;
        cyc(2);
        `CHK(powerDown, 1'b0)
    endtask
    task automatic t_mac;
        lineRxDv = 1'b1;
        lineRxd = 8'hc3;
        lineCrs = 1'b1;
        macTxEn = 1'b1;
        macTxEr = 1'b1;
        macTxd = 8'ha5;
        cyc(2);
        `CHK(macRxd, 8'hc3)
        `CHK(macCrs, 1'b1)
        `CHK({lineTxEn, lineTxEr, lineTxd}, 10'h3a5)
        lineRxDv = 1'b0;
        lineCrs = 1'b0;
        macTxEn = 1'b0;
        macTxEr = 1'b0;
        wr(16'h4000);
        cyc(4);
        macTxEn = 1'b1;
        macTxd = 8'h5a;
        macTxEr = 1'b1;
        cyc(2);
        `CHK(macRxd, 8'h5a)
        `CHK(macRxDv, 1'b1)
        `CHK({macRxEr, macCrs, lineTxEn}, 3'h6)
        wr(16'h4080);
        cyc(2);
        `CHK(macCol, 1'b1)
        macTxEn = 1'b0;
        macTxEr = 1'b0;
        cyc(2);
        `CHK(macCol, 1'b0)
        wr(16'h0400);
        `CHK(macDriveEn, 1'b0)
        rdr(5'h00, rv);
        `CHK(rv, 16'h0400)
        wr(16'h0040);
        `CHK(macDriveEn, 1'b1)
    endtask
    task automatic t_soft;
        strapAnEnable = 1'b1;
        strapDuplex = 1'b0;
        wr(16'hc000);
        `CHK(softResetBusy, 1'b1)
        rdr(5'h00, rv);
        `CHK(rv[15], 1'b1)
        cyc(8);
        `CHK(softResetBusy, 1'b0)
        rdr(5'h00, rv);
        `CHK(rv, 16'h1040)
        `CHK(anEnable, 1'b1)
        wr(16'h0040);
        `CHK(anEnable, 1'b0)
    endtask

    task automatic finish_test;
        $display("mismatches %0d of %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        cyc(2);
        t_reset;
        t_forced;
        t_auto;
        t_power;
        t_mac;
        t_soft;
        finish_test;
    end
    initial begin
        #300_000;
        n_mismatch++;
        finish_test;
    end
endmodule // bmc_basic_control_tb

/* File: test/bmc_mdio_master.sv */
// management serial master model driving mdc and mdio
`timescale 1ns/10ps
module bmc_mdio_master (
    input wire logic clk,
    output logic mdc,
    output logic mdioIn,
    input wire logic mdioOut,
    input wire logic mdioOe
);
    import bmc_pkg::*;
    logic drv = 1'b0;
    logic val = 1'b1;
    initial mdc = 1'b0;
    assign mdioIn = drv ? val : (mdioOe ? mdioOut : 1'b1);
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
                        input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] rd);
        logic [31:0] fr;
        fr = {2'b01, op, phy, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int k = 0; k < 32; k++) begin
            drv = !(op == BMC_OP_READ && k >= 14);
            val = fr[31 - k];
            repeat (2) @(posedge clk);
            #1;
            if (k >= 16) rd = {rd[14:0], mdioIn};
            mdc = 1'b1;
            repeat (2) @(posedge clk);
            #1 mdc = 1'b0;
        end
        drv = 1'b0;
    endtask
endmodule // bmc_mdio_master

/* File: test/bmc_props.sv */
// port assertions for the basic mode control block
`timescale 1ns/10ps
module bmc_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic powerOffRequestN,
    input wire logic anStarted,
    input wire logic [1:0] anSpeed,
    input wire logic softResetBusy,
    input wire logic anEnable,
    input wire logic anRestartReq,
    input wire logic [1:0] speedSel,
    input wire logic powerDown,
    input wire logic macTxEn,
    input wire logic lineCol,
    input wire logic lineTxEn,
    input wire logic macRxDv,
    input wire logic macCol,
    input wire logic macCrs,
    input wire logic macDriveEn
);
    import bmc_pkg::*;
    logic [7:0] busyCnt_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busyCnt_r <= 8'h00;
        end else begin
            busyCnt_r <= softResetBusy ? busyCnt_r + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_tx_idle;
        !macTxEn && !lineCol;
    endsequence
    sequence s_col_rise;
        $rose(macCol) && !$past(lineCol);
    endsequence
    a_pin_pdown: assert property (
        !powerOffRequestN |=> powerDown) else $error("pin ignored");
    a_pdown_quiet: assert property (
        powerDown ##1 powerDown |-> !lineTxEn && !macRxDv)
        else $error("data during power down");
    a_iso_quiet: assert property (
        !macDriveEn |-> !macRxDv && !macCol && !macCrs)
        else $error("data while isolated");
    a_an_speed: assert property (
        anEnable && $past(anEnable) |-> speedSel == $past(anSpeed))
        else $error("forced speed used");
    a_restart_gate: assert property (
        $rose(anRestartReq) |-> anEnable) else $error("restart ungated");
    a_restart_hold: assert property (
        $fell(anRestartReq) |-> $past(anStarted) || $past(softResetBusy))
        else $error("restart cleared early");
    a_col_start: assert property (
        s_col_rise |-> $past(macTxEn)) else $error("col without tx");
    a_col_stop: assert property (
        s_tx_idle |=> !macCol) else $error("col held");
    a_sreset_len: assert property (
        $fell(softResetBusy) |-> busyCnt_r >= BMC_SW_RESET_CYC - 8'h01)
        else $error("soft reset short");
    a_sreset_cap: assert property (
        softResetBusy |-> busyCnt_r <= BMC_SW_RESET_CYC + 8'h01)
        else $error("soft reset long");
endmodule // bmc_props

bind bmc_basic_control bmc_props u_props (
    .clk, .rst_n, .powerOffRequestN, .anStarted, .anSpeed,
    .softResetBusy, .anEnable, .anRestartReq, .speedSel, .powerDown,
    .macTxEn, .lineCol, .lineTxEn, .macRxDv, .macCol, .macCrs,
    .macDriveEn
);
